// *** hw/tapr_pkg.sv ***
// Constants, register map and carrier types of the trim and packet register bank
package tapr_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_IF_FILTER = 8'h55;
  localparam logic [7:0] IDX_RX_TRIM = 8'h56;
  localparam logic [7:0] IDX_SYNTH = 8'h57;
  localparam logic [7:0] IDX_ANTENNA = 8'h58;
  localparam logic [7:0] IDX_RSSI = 8'h59;
  localparam logic [7:0] IDX_DISC = 8'h5a;
  localparam logic [7:0] IDX_XTAL = 8'h5b;
  localparam logic [7:0] IDX_AMP_TEMP = 8'h5c;
  localparam logic [7:0] IDX_PTAT = 8'h5d;
  localparam logic [7:0] IDX_MISC = 8'h5e;
  localparam logic [7:0] IDX_CHECKSUM = 8'h5f;
  localparam logic [7:0] IDX_NV_KEY = 8'h60;
  localparam logic [7:0] IDX_PKT_LEN = 8'h61;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h62;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h63;
  localparam logic [7:0] IDX_NV_CMD = 8'h64;
  localparam logic [7:0] IDX_TEMP_ADC = 8'h6a;
  localparam logic [7:0] IDX_CH1_ADC = 8'h6b;
  localparam logic [7:0] IDX_CH2_ADC = 8'h6c;
  localparam logic [7:0] IDX_CH3_ADC = 8'h6d;
  localparam logic [7:0] IDX_PKT_FIRST = 8'h70;
  localparam logic [7:0] IDX_PKT_LAST = 8'h7f;
  localparam int TRIM_REGS = 9;
  // Field positions
  localparam int F_NIB_HI = 4;
  localparam int F_CAL_OK = 7;
  localparam int F_GAIN = 6;
  localparam int F_INT_FILTER = 3;
  localparam int F_SQUELCH = 2;
  localparam int F_CYCLE_SLIP = 1;
  localparam int F_AUTO_COMP = 0;
  localparam int F_NV_GO = 0;
  localparam int F_EV_PKT_DONE = 0;
  localparam int F_EV_NV_REFUSED = 1;
  localparam int EV_W = 2;
  // Reset values and keys
  localparam logic [7:0] TRIM_RST = 8'h00;
  localparam logic [7:0] NV_KEY_RST = 8'h00;
  localparam logic [7:0] NV_KEY = 8'h95;
  localparam logic [7:0] PKT_LEN_RST = 8'h00;
  localparam int PKT_BITS = 128;
  localparam logic [7:0] PKT_MAX = 8'h80;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [3:0] if_center;
    logic [3:0] if_bandwidth;
    logic front_amp_gain_select;
    logic [5:0] image_reject_amplitude_trim;
    logic [3:0] image_reject_phase_trim;
    logic internal_loop_filter;
    logic [2:0] charge_pump_code;
    logic [3:0] antenna_cap_code;
    logic [1:0] rssi_temp_slope;
    logic [1:0] rssi_offset;
    logic [3:0] rssi_resistor;
    logic [3:0] disc_bandwidth;
    logic [3:0] disc_offset;
    logic [7:0] crystal_current;
    logic [7:0] amp_temp_sensor;
    logic [7:0] ptat_bias;
    logic fsk_squelch_en;
    logic cycle_slip_en;
    logic auto_comp_en;
  } tapr_trim_s;

  typedef struct packed {
    logic [7:0] temperature;
    logic [7:0] channel_one;
    logic [7:0] channel_two;
    logic [7:0] channel_three;
  } tapr_adc_s;
endpackage : tapr_pkg

// *** hw/tapr_regs.sv ***
// AXI4-Lite register bank with analog trims, ADC results and packet capture
`timescale 1ns/100ps
// Notes on behaviour
// - IF trim: centre upper nibble, bandwidth lower
// - Bit7 calibrated flag, bit6 gain, 5:0 trim
// - Bit3 internal loop filter, 2:0 pump current
// - Antenna nibble: upper in transmit, lower receive
// - RSSI slope 7:6, offset 5:4, resistor 3:0
// - Discriminator bandwidth 7:4, offset 3:0
// - Misc: user bits, squelch, slip, auto-compensation
// - Array writes only while key equals 0x95
// - Checksum register shows array checksum value
// - Temperature result read-only at 0x6A
// - Channel results read-only at 0x6B-0x6D
// - Capture only when packet length non-zero
// - Recovered bits shift in per baud clock
// - Last bit lands in LSB of 0x7F; first bit in MSB of 0x70 at length 128
// - Length counts bits, zero off, max 128
module tapr_regs (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [tapr_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [tapr_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [tapr_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [tapr_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tx_active,
  input wire logic fast_start_oscillator_cal_ok,
  input wire tapr_pkg::tapr_adc_s adc_results,
  input wire logic [7:0] nv_checksum,
  input wire logic capture_start,
  input wire logic cdr_data,
  input wire logic cdr_baud_clk,
  output tapr_pkg::tapr_trim_s trim,
  output logic nv_write_go,
  output logic packet_done,
  output logic irq
);
  import tapr_pkg::*;

  logic [7:0] trim_q [TRIM_REGS];
  logic [7:0] misc_q;
  logic [7:0] nv_write_key;
  logic [7:0] pkt_len;
  logic [EV_W-1:0] irq_stat;
  logic [EV_W-1:0] irq_mask;
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;
  logic [EV_W-1:0] next_irq_stat;

  logic aw_full;
  logic w_full;
  logic [7:0] aw_idx;
  logic [7:0] w_data;
  logic w_lane0;
  logic wr_en;
  logic [7:0] ar_idx;
  logic rd_take;
  logic [7:0] rd_val;
  logic rd_hit;

  logic [2:0] baud_sync;
  logic [1:0] data_sync;
  logic baud_edge;
  logic cap_active;
  logic [7:0] bit_cnt;
  logic [7:0] eff_len;
  logic [PKT_BITS-1:0] shreg;
  logic nv_cmd_hit;

  // Write channel: address and data taken in either order
  assign s_axi_awready = !aw_full && !s_axi_bvalid;
  assign s_axi_wready = !w_full && !s_axi_bvalid;
  assign wr_en = aw_full && w_full && !s_axi_bvalid;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aw_full <= 1'b0;
      aw_idx <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full <= 1'b1;
      aw_idx <= s_axi_awaddr[9:2];
    end else if (wr_en) begin
      aw_full <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      w_full <= 1'b0;
      w_data <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full <= 1'b1;
      w_data <= s_axi_wdata[7:0];
      w_lane0 <= s_axi_wstrb[0];
    end else if (wr_en) begin
      w_full <= 1'b0;
    end
  end

  function automatic logic writable(input logic [7:0] idx);
    writable = (idx >= IDX_IF_FILTER && idx <= IDX_NV_KEY) ||
               (idx >= IDX_PKT_LEN && idx <= IDX_NV_CMD && idx != IDX_IRQ_STAT);
  endfunction : writable

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_en) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= writable(aw_idx) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Trim and configuration storage; lane 0 carries the byte
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < TRIM_REGS; i++) begin
        trim_q[i] <= TRIM_RST;
      end
      misc_q <= TRIM_RST;
      nv_write_key <= NV_KEY_RST;
      pkt_len <= PKT_LEN_RST;
      irq_mask <= '0;
    end else if (wr_en && w_lane0) begin
      if (aw_idx >= IDX_IF_FILTER && aw_idx <= IDX_PTAT) begin
        trim_q[4'(aw_idx - IDX_IF_FILTER)] <= w_data;
      end
      if (aw_idx == IDX_MISC) begin
        misc_q <= w_data;
      end
      if (aw_idx == IDX_NV_KEY) begin
        nv_write_key <= w_data;
      end
      if (aw_idx == IDX_PKT_LEN) begin
        pkt_len <= w_data;
      end
      if (aw_idx == IDX_IRQ_MASK) begin
        irq_mask <= w_data[EV_W-1:0];
      end
    end
  end

  // Array write request gated by the unlock key
  assign nv_cmd_hit = wr_en && w_lane0 && aw_idx == IDX_NV_CMD && w_data[F_NV_GO];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      nv_write_go <= 1'b0;
    end else begin
      nv_write_go <= nv_cmd_hit && nv_write_key == NV_KEY;
    end
  end

  // Decoded trim fields
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      trim <= '0;
    end else begin
      trim.if_center <= trim_q[0][7:F_NIB_HI];
      trim.if_bandwidth <= trim_q[0][F_NIB_HI-1:0];
      trim.front_amp_gain_select <= trim_q[1][F_GAIN];
      trim.image_reject_amplitude_trim <= trim_q[1][5:0];
      trim.image_reject_phase_trim <= trim_q[2][7:F_NIB_HI];
      trim.internal_loop_filter <= trim_q[2][F_INT_FILTER];
      trim.charge_pump_code <= trim_q[2][2:0];
      // Same capacitor, so only one nibble reaches it at a time
      trim.antenna_cap_code <= tx_active ? trim_q[3][7:F_NIB_HI] : trim_q[3][3:0];
      trim.rssi_temp_slope <= trim_q[4][7:6];
      trim.rssi_offset <= trim_q[4][5:4];
      trim.rssi_resistor <= trim_q[4][3:0];
      trim.disc_bandwidth <= trim_q[5][7:F_NIB_HI];
      trim.disc_offset <= trim_q[5][F_NIB_HI-1:0];
      trim.crystal_current <= trim_q[6];
      trim.amp_temp_sensor <= trim_q[7];
      trim.ptat_bias <= trim_q[8];
      trim.fsk_squelch_en <= misc_q[F_SQUELCH];
      trim.cycle_slip_en <= misc_q[F_CYCLE_SLIP];
      trim.auto_comp_en <= misc_q[F_AUTO_COMP];
    end
  end

  // Read channel
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign ar_idx = s_axi_araddr[9:2];

  always_comb begin
    rd_val = 8'h00;
    rd_hit = 1'b1;
    if (ar_idx >= IDX_PKT_FIRST && ar_idx <= IDX_PKT_LAST) begin
      // Lowest index holds the most significant byte
      rd_val = shreg[PKT_BITS-1-8*(ar_idx-IDX_PKT_FIRST) -: 8];
    end else if (ar_idx >= IDX_IF_FILTER && ar_idx <= IDX_PTAT) begin
      rd_val = trim_q[4'(ar_idx - IDX_IF_FILTER)];
      if (ar_idx == IDX_RX_TRIM) begin
        rd_val[F_CAL_OK] = fast_start_oscillator_cal_ok;
      end
    end else begin
      unique case (ar_idx)
        IDX_MISC: rd_val = {misc_q[7:4], 1'b0, misc_q[2:0]};
        IDX_CHECKSUM: rd_val = nv_checksum;
        IDX_NV_KEY: rd_val = nv_write_key;
        IDX_PKT_LEN: rd_val = pkt_len;
        IDX_IRQ_STAT: rd_val = {{(8-EV_W){1'b0}}, irq_stat};
        IDX_IRQ_MASK: rd_val = {{(8-EV_W){1'b0}}, irq_mask};
        IDX_NV_CMD: rd_val = 8'h00;
        IDX_TEMP_ADC: rd_val = adc_results.temperature;
        IDX_CH1_ADC: rd_val = adc_results.channel_one;
        IDX_CH2_ADC: rd_val = adc_results.channel_two;
        IDX_CH3_ADC: rd_val = adc_results.channel_three;
        default: rd_hit = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_val};
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Interrupt status: read clears, a same-cycle event wins
  always_comb begin
    ev_set = '0;
    ev_set[F_EV_PKT_DONE] = packet_done;
    ev_set[F_EV_NV_REFUSED] = nv_cmd_hit && nv_write_key != NV_KEY;
    ev_clr = (rd_take && ar_idx == IDX_IRQ_STAT) ? {EV_W{1'b1}} : '0;
    next_irq_stat = (irq_stat & ~ev_clr) | ev_set;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= next_irq_stat;
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // Recovered clock and data come from another domain
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      baud_sync <= 3'b000;
      data_sync <= 2'b00;
    end else begin
      baud_sync <= {baud_sync[1:0], cdr_baud_clk};
      data_sync <= {data_sync[0], cdr_data};
    end
  end

  // Baud clock must stay below half the system clock rate
  assign baud_edge = baud_sync[1] && !baud_sync[2];
  assign eff_len = (pkt_len > PKT_MAX) ? PKT_MAX : pkt_len;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cap_active <= 1'b0;
      bit_cnt <= 8'h00;
      shreg <= '0;
      packet_done <= 1'b0;
    end else begin
      packet_done <= 1'b0;
      if (capture_start) begin
        cap_active <= eff_len != 8'h00;
        bit_cnt <= 8'h00;
        shreg <= '0;
      end else if (cap_active && baud_edge) begin
        shreg <= {shreg[PKT_BITS-2:0], data_sync[1]};
        bit_cnt <= bit_cnt + 8'h01;
        if (bit_cnt + 8'h01 >= eff_len) begin
          cap_active <= 1'b0;
          packet_done <= 1'b1;
        end
      end
    end
  end
endmodule : tapr_regs

// *** verif/tapr_regs_sva.sv ***
// Port checker for the trim and packet register bank
`timescale 1ns/100ps
module tapr_regs_sva
  import tapr_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic nv_write_go,
  input wire logic packet_done,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channel open during response");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address open during data");
  b_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("response repeated");
  r_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  rd_err_a: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read with data");
  done_pulse_a: assert property (packet_done |=> !packet_done)
    else $error("packet done longer than one cycle");
  go_pulse_a: assert property (nv_write_go |=> !nv_write_go)
    else $error("array write pulse too long");
  go_cause_a: assert property (nv_write_go |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("array write without bus write");

  cover property (packet_done);
  cover property (nv_write_go);
  cover property ($rose(irq));
  cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule : tapr_regs_sva

bind tapr_regs tapr_regs_sva chk_u (.clk, .nrst, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .nv_write_go, .packet_done, .irq);

// *** verif/tb_top.sv ***
// Self-checking bench for the trim and packet register bank
`timescale 1ns/100ps
module tb_top;
  import tapr_pkg::*;
  logic clk = 1'h0, nrst = 1'h0, awv = 1'h0, wv = 1'h0, arv = 1'h0, tx = 1'h0, cal = 1'h0;
  logic cs = 1'h0, cd = 1'h0, cb = 1'h0, awr, wrd, bv, arr, rvl, go, done, irq;
  logic [9:0] awa = 10'h0, ara = 10'h0;
  logic [31:0] wd = 32'h0, rdat;
  logic [1:0] br, rsp;
  logic [7:0] cks = 8'h5c;
  logic [127:0] pk = 128'h0123456789abcdeffedcba9876543210;
  tapr_adc_s adc = {8'h11, 8'h22, 8'h33, 8'h44};
  tapr_trim_s trim;
  int err_total = 0, check_count = 0, cyc = 0, ngo = 0, ndone = 0;

  tapr_regs dut_u (.clk(clk), .nrst(nrst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(1'h1),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rsp), .s_axi_rvalid(rvl), .s_axi_rready(1'h1), .tx_active(tx),
    .fast_start_oscillator_cal_ok(cal), .adc_results(adc), .nv_checksum(cks),
    .capture_start(cs), .cdr_data(cd), .cdr_baud_clk(cb), .trim(trim),
    .nv_write_go(go), .packet_done(done), .irq(irq));

  always #5 clk = ~clk;

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  // Ceiling well above the roughly 1100 cycles the sequence needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (go === 1'h1) ngo <= ngo + 1;
    if (done === 1'h1) ndone <= ndone + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // First wait is unconditional: the last answer's valid is still seen at entry
  task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] e = RESP_OKAY);
    int n = 0;
    awa <= {i, 2'h0};
    wd <= {24'h0, d};
    awv <= 1'h1;
    wv <= 1'h1;
    do begin
      @(posedge clk);
      if (awr === 1'h1) awv <= 1'h0;
      if (wrd === 1'h1) wv <= 1'h0;
      n++;
    end while (bv !== 1'h1 && n < 20);
    // A write that never answers counts as a mismatch
    chk(32'(bv), 32'h1);
    chk(32'(br), 32'(e));
  endtask : wr

  task automatic rd(input logic [7:0] i, input logic [7:0] e, input logic [1:0] er = RESP_OKAY);
    int n = 0;
    ara <= {i, 2'h0};
    arv <= 1'h1;
    do begin
      @(posedge clk);
      if (arr === 1'h1) arv <= 1'h0;
      n++;
    end while (rvl !== 1'h1 && n < 20);
    chk(32'(rvl), 32'h1);
    chk(rdat, {24'h0, e});
    chk(32'(rsp), 32'(er));
  endtask : rd

  // Baud period of six cycles, three high and three low
  task automatic bit_in(input logic b);
    cd <= b;
    repeat (3) @(posedge clk);
    cb <= 1'h1;
    repeat (3) @(posedge clk);
    cb <= 1'h0;
  endtask : bit_in

  task automatic start;
    cs <= 1'h1;
    @(posedge clk);
    cs <= 1'h0;
  endtask : start

  initial begin
    int i;
    repeat (6) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    for (i = 8'h55; i <= 8'h64; i++) rd(i[7:0], (i == 8'h5f) ? cks : 8'h0);
    wr(8'h55, 8'ha5);
    wr(8'h56, 8'h7f);
    wr(8'h57, 8'h5b);
    wr(8'h58, 8'h3c);
    wr(8'h59, 8'hb6);
    wr(8'h5a, 8'hf0);
    wr(8'h5e, 8'hae);
    wr(8'h5d, 8'hc3);
    wr(8'h5b, 8'h69);
    wr(8'h5c, 8'h2d);
    repeat (2) @(posedge clk);
    chk(32'({trim.if_center, trim.if_bandwidth}), 32'ha5);
    chk(32'({trim.front_amp_gain_select, trim.image_reject_amplitude_trim}), 32'h7f);
    chk(32'({trim.image_reject_phase_trim, trim.internal_loop_filter, trim.charge_pump_code}),
      32'h5b);
    chk(32'(trim.antenna_cap_code), 32'hc);
    chk(32'({trim.rssi_temp_slope, trim.rssi_offset, trim.rssi_resistor}), 32'hb6);
    chk(32'({trim.disc_bandwidth, trim.disc_offset}), 32'hf0);
    chk(32'({trim.fsk_squelch_en, trim.cycle_slip_en, trim.auto_comp_en}), 32'h6);
    chk(32'(trim.ptat_bias), 32'hc3);
    chk(32'(trim.crystal_current), 32'h69);
    chk(32'(trim.amp_temp_sensor), 32'h2d);
    tx <= 1'h1;
    cal <= 1'h1;
    rd(8'h56, 8'hff);
    rd(8'h5e, 8'ha6);
    chk(32'(trim.antenna_cap_code), 32'h3);
    for (i = 0; i < 4; i++) rd(8'(8'h6a + i), 8'(8'h11 * (i + 1)));
    // Result registers refuse writes with an error response
    wr(8'h6a, 8'hee, RESP_SLVERR);
    rd(8'h6a, 8'h11);
    rd(8'h40, 8'h0, RESP_SLVERR);
    wr(8'h40, 8'h1, RESP_SLVERR);
    wr(8'h5f, 8'h77);
    rd(8'h5f, 8'h5c);
    wr(8'h64, 8'h01);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
    wr(8'h63, 8'h03);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h1);
    rd(8'h62, 8'h02);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
    wr(8'h60, 8'h95);
    wr(8'h64, 8'h01);
    wr(8'h60, 8'h00);
    wr(8'h64, 8'h01);
    rd(8'h62, 8'h02);
    chk(32'(ngo), 32'h1);
    // Zero length: bits must be ignored
    start();
    for (i = 0; i < 8; i++) bit_in(1'h1);
    repeat (4) @(posedge clk);
    chk(32'(ndone), 32'h0);
    rd(8'h7f, 8'h00);
    wr(8'h61, 8'h08);
    start();
    for (i = 0; i < 12; i++) bit_in((i < 8) ? pk[127 - i] : 1'h1);
    repeat (4) @(posedge clk);
    chk(32'(ndone), 32'h1);
    rd(8'h7f, 8'h01);
    rd(8'h7e, 8'h00);
    rd(8'h62, 8'h01);
    // Length above the maximum behaves as a full packet
    wr(8'h61, 8'hc8);
    start();
    for (i = 0; i < 128; i++) bit_in(pk[127 - i]);
    repeat (4) @(posedge clk);
    chk(32'(ndone), 32'h2);
    for (i = 0; i < 16; i++) rd(8'(8'h70 + i), pk[127 - 8 * i -: 8]);
    report_and_stop();
  end
endmodule : tb_top
